// ---- design/zsd_defs.svh ----
// register map, field layouts, resets and limits of the zero stuff decimator
`ifndef ZSD_DEFS_SVH
`define ZSD_DEFS_SVH
`define ZSD_CTRL_OFF 12'h000
`define ZSD_RATE_OFF 12'h004
`define ZSD_SHIFT_OFF 12'h008
`define ZSD_SCALE_OFF 12'h00C
`define ZSD_PHASE_OFF 12'h010
`define ZSD_STAT_OFF 12'h014
`define ZSD_DATA_OFF 12'h018
`define ZSD_CTRL_EN_BIT 0
`define ZSD_RATE_RST 16'h0010
`define ZSD_RATE_MIN 16'h0010
`define ZSD_SHIFT_RST 7'h37
`define ZSD_SHIFT_BIAS 7'h1A
`define ZSD_SCALE_RST 16'h8000
`define ZSD_PHASE_RST 16'h0000
`define ZSD_FIR_DECIM 2'h3
`define ZSD_FIFO_DEPTH 16
`define ZSD_FIFO_AW 4
`define ZSD_DATA_W 32
`endif

// ---- design/zsd_pkg.sv ----
// types shared by the zero stuff decimator files
package zsd_pkg;
  typedef logic signed [15:0] zsd_sample_t;
  typedef logic signed [79:0] zsd_acc_t;
  typedef enum logic [1:0] {zsd_idle, zsd_run} zsd_state_t;
endpackage

// ---- design/zsd_fifo.sv ----
// parameterised first-in first-out buffer with valid and ready
`timescale 1ns/1ns
`default_nettype none
module zsd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  // full and empty come from the count, so they are exact
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign level = cnt_reg;
endmodule // zsd_fifo
`default_nettype wire

// ---- design/zsd_core.sv ----
// down converter front end: mixer, high decimation filter, gain correction
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "zsd_defs.svh"
module zsd_core (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // zero-stuffed sample stream, one per clock
  input wire zsd_pkg::zsd_sample_t stuffed_sample,
  // quadrature output stream
  output logic out_valid,
  output logic [31:0] out_iq,
  output logic overflow
);
  import zsd_pkg::*;

  // control state
  logic en_reg, en_next;
  logic [15:0] coarse_decim_rate_reg, coarse_decim_rate_next;
  logic [6:0] shift_reg, shift_next;
  logic [15:0] scale_reg, scale_next;
  logic [15:0] phase_inc_reg, phase_inc_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic ovf_reg, ovf_next;
  // datapath state
  logic [15:0] phase_reg, phase_next;
  zsd_acc_t integ_reg [2][5];
  zsd_acc_t integ_next [2][5];
  zsd_acc_t comb_reg [2][5];
  zsd_acc_t comb_next [2][5];
  zsd_acc_t combd_reg [2][5];
  zsd_acc_t combd_next [2][5];
  logic [15:0] dec_cnt_reg, dec_cnt_next;
  logic [1:0] fir_cnt_reg, fir_cnt_next;
  logic signed [15:0] scaled_reg [2];
  logic signed [15:0] scaled_next [2];
  logic scaled_vld_reg, scaled_vld_next;
  logic signed [17:0] fir_acc_reg [2];
  logic signed [17:0] fir_acc_next [2];
  zsd_state_t state_reg, state_next;
  // fifo link
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid;
  logic [31:0] fifo_in_data, fifo_out_data;
  logic [4:0] fifo_level;
  logic out_valid_reg, out_valid_next;
  logic [31:0] out_iq_reg, out_iq_next;
  logic pop;

  // quarter-wave sine table, coarse but enough for a mixer
  function automatic logic signed [15:0] lo_wave(input logic [15:0] ph);
    logic [1:0] quad;
    logic signed [15:0] mag;
    quad = ph[15:14];
    unique case (ph[13:12])
      2'h0: mag = 16'sh0000;
      2'h1: mag = 16'sh30FB;
      2'h2: mag = 16'sh5A82;
      2'h3: mag = 16'sh7641;
    endcase
    if (quad[0]) begin
      unique case (ph[13:12])
        2'h0: mag = 16'sh7FFF;
        2'h1: mag = 16'sh7641;
        2'h2: mag = 16'sh5A82;
        2'h3: mag = 16'sh30FB;
      endcase
    end
    lo_wave = quad[1] ? -mag : mag;
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  logic setup;
  assign setup = psel && !penable;

  // apb: zero-wait answer, registered on the setup cycle
  always_comb begin
    en_next = en_reg;
    coarse_decim_rate_next = coarse_decim_rate_reg;
    shift_next = shift_reg;
    scale_next = scale_reg;
    phase_inc_next = phase_inc_reg;
    prdata_next = prdata_reg;
    pready_next = setup;
    pslverr_next = 1'b0;
    pop = 1'b0;
    if (setup && pwrite) begin
      if (hit(paddr, `ZSD_CTRL_OFF)) begin
        en_next = pwdata[`ZSD_CTRL_EN_BIT];
      end else if (hit(paddr, `ZSD_RATE_OFF)) begin
        // rates under sixteen are clamped to the minimum
        coarse_decim_rate_next = (pwdata[15:0] < `ZSD_RATE_MIN) ?
          `ZSD_RATE_MIN : pwdata[15:0];
      end else if (hit(paddr, `ZSD_SHIFT_OFF)) begin
        shift_next = pwdata[6:0];
      end else if (hit(paddr, `ZSD_SCALE_OFF)) begin
        scale_next = pwdata[15:0];
      end else if (hit(paddr, `ZSD_PHASE_OFF)) begin
        phase_inc_next = pwdata[15:0];
      end else if (!hit(paddr, `ZSD_STAT_OFF)) begin
        pslverr_next = 1'b1;
      end
    end else if (setup) begin
      prdata_next = 32'h0000_0000;
      if (hit(paddr, `ZSD_CTRL_OFF)) begin
        prdata_next = {31'h0, en_reg};
      end else if (hit(paddr, `ZSD_RATE_OFF)) begin
        prdata_next = {16'h0, coarse_decim_rate_reg};
      end else if (hit(paddr, `ZSD_SHIFT_OFF)) begin
        prdata_next = {25'h0, shift_reg};
      end else if (hit(paddr, `ZSD_SCALE_OFF)) begin
        prdata_next = {16'h0, scale_reg};
      end else if (hit(paddr, `ZSD_PHASE_OFF)) begin
        prdata_next = {16'h0, phase_inc_reg};
      end else if (hit(paddr, `ZSD_STAT_OFF)) begin
        prdata_next = {25'h0, ovf_reg, fifo_level, state_reg == zsd_run};
      end else if (hit(paddr, `ZSD_DATA_OFF)) begin
        // reading the data word pops it; empty reads as zero
        prdata_next = fifo_out_valid ? fifo_out_data : 32'h0;
        pop = fifo_out_valid;
      end else begin
        pslverr_next = 1'b1;
      end
    end
  end

  // next values of the signal path
  always_comb begin
    logic signed [15:0] lo_i, lo_q;
    logic signed [31:0] mix [2];
    logic dump;
    logic signed [31:0] prod;
    zsd_acc_t hdf_in;
    prod = 32'sh0000_0000;
    hdf_in = '0;
    lo_i = lo_wave(phase_reg + 16'h4000);
    lo_q = lo_wave(phase_reg);
    mix[0] = stuffed_sample * lo_i;
    mix[1] = stuffed_sample * lo_q;
    state_next = en_reg ? zsd_run : zsd_idle;
    phase_next = en_reg ? phase_reg + phase_inc_reg : 16'h0;
    dump = en_reg && (dec_cnt_reg == coarse_decim_rate_reg - 16'h1);
    dec_cnt_next = !en_reg ? 16'h0 : dump ? 16'h0 : dec_cnt_reg + 16'h1;
    scaled_vld_next = dump;
    fir_cnt_next = fir_cnt_reg;
    ovf_next = ovf_reg;
    out_valid_next = 1'b0;
    out_iq_next = out_iq_reg;
    for (int c = 0; c < 2; c++) begin
      // input shifter: power-of-two part of the gain correction; the
      // mixer product carries 15 spare fraction bits and the output
      // window sits 11 bits under 75, hence the fixed bias
      if (shift_reg >= `ZSD_SHIFT_BIAS) begin
        hdf_in = zsd_acc_t'(mix[c]) <<< (shift_reg - `ZSD_SHIFT_BIAS);
      end else begin
        hdf_in = zsd_acc_t'(mix[c]) >>> (`ZSD_SHIFT_BIAS - shift_reg);
      end
      integ_next[c][0] = integ_reg[c][0] + hdf_in;
      for (int s = 1; s < 5; s++) begin
        integ_next[c][s] = integ_reg[c][s] + integ_reg[c][s-1];
      end
      comb_next[c] = comb_reg[c];
      combd_next[c] = combd_reg[c];
      scaled_next[c] = scaled_reg[c];
      fir_acc_next[c] = fir_acc_reg[c];
      if (dump) begin
        // decimate before the combs, so no multiplier is needed
        comb_next[c][0] = integ_reg[c][4] - combd_reg[c][0];
        combd_next[c][0] = integ_reg[c][4];
        for (int s = 1; s < 5; s++) begin
          comb_next[c][s] = comb_next[c][s-1] - combd_reg[c][s];
          combd_next[c][s] = comb_next[c][s-1];
        end
        // top 16 bits: unit gain after shift, msb on the bus msb
        prod = $signed(comb_next[c][4][79:64]) *
          $signed({1'b0, scale_reg[15:1]});
        scaled_next[c] = prod[29:14];
        if (prod[30] != prod[29]) begin
          ovf_next = 1'b1;
        end
      end
      if (scaled_vld_reg) begin
        fir_acc_next[c] = (fir_cnt_reg == 2'h0) ?
          18'(scaled_reg[c]) : fir_acc_reg[c] + 18'(scaled_reg[c]);
      end
      if (!en_reg) begin
        for (int s = 0; s < 5; s++) begin
          integ_next[c][s] = '0;
          comb_next[c][s] = '0;
          combd_next[c][s] = '0;
        end
      end
    end
    // quadrature output stage: fixed decimate by four
    if (scaled_vld_reg) begin
      fir_cnt_next = fir_cnt_reg + 2'h1;
    end
    if (pop) begin
      out_valid_next = 1'b1;
      out_iq_next = fifo_out_data;
    end
  end

  assign fifo_in_valid = scaled_vld_reg && (fir_cnt_reg == `ZSD_FIR_DECIM);
  assign fifo_in_data = {fir_acc_next[0][17:2], fir_acc_next[1][17:2]};

  // control and bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= 1'b0;
      coarse_decim_rate_reg <= `ZSD_RATE_RST;
      shift_reg <= `ZSD_SHIFT_RST;
      scale_reg <= `ZSD_SCALE_RST;
      phase_inc_reg <= `ZSD_PHASE_RST;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
      coarse_decim_rate_reg <= coarse_decim_rate_next;
      shift_reg <= shift_next;
      scale_reg <= scale_next;
      phase_inc_reg <= phase_inc_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // signal path registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= zsd_idle;
      phase_reg <= 16'h0;
      dec_cnt_reg <= 16'h0;
      fir_cnt_reg <= 2'h0;
      scaled_vld_reg <= 1'b0;
      ovf_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_iq_reg <= 32'h0;
      for (int c = 0; c < 2; c++) begin
        scaled_reg[c] <= '0;
        fir_acc_reg[c] <= '0;
        for (int s = 0; s < 5; s++) begin
          integ_reg[c][s] <= '0;
          comb_reg[c][s] <= '0;
          combd_reg[c][s] <= '0;
        end
      end
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      dec_cnt_reg <= dec_cnt_next;
      fir_cnt_reg <= fir_cnt_next;
      scaled_vld_reg <= scaled_vld_next;
      ovf_reg <= ovf_next;
      out_valid_reg <= out_valid_next;
      out_iq_reg <= out_iq_next;
      scaled_reg <= scaled_next;
      fir_acc_reg <= fir_acc_next;
      integ_reg <= integ_next;
      comb_reg <= comb_next;
      combd_reg <= combd_next;
    end
  end

  // output words wait here until software drains them
  zsd_fifo #(
    .WIDTH(`ZSD_DATA_W),
    .DEPTH(`ZSD_FIFO_DEPTH),
    .AW(`ZSD_FIFO_AW)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign out_valid = out_valid_reg;
  assign out_iq = out_iq_reg;
  assign overflow = ovf_reg;
endmodule // zsd_core
`default_nettype wire

// ---- tb/zsd_core_monitor.sv ----
// checker on the zero stuff decimator ports
`timescale 1ns/1ns
`default_nettype none
`include "zsd_defs.svh"
module zsd_core_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // stream
  input wire logic out_valid,
  input wire logic overflow
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // setup cycle, then a read setup of one address
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence rd_s(logic [11:0] a);
    setup_s ##0 (!pwrite && paddr == a);
  endsequence
  ready_next_a: assert property (setup_s |=> pready && penable)
    else $error("no ready in access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (
    setup_s ##0 paddr > `ZSD_DATA_OFF |=> pslverr)
    else $error("unmapped access not refused");
  data_wr_err_a: assert property (
    setup_s ##0 (pwrite && paddr == `ZSD_DATA_OFF) |=> pslverr)
    else $error("data write not refused");
  rate_floor_a: assert property (
    rd_s(`ZSD_RATE_OFF) |=> prdata[15:0] >= `ZSD_RATE_MIN)
    else $error("rate below minimum");
  shift_width_a: assert property (
    rd_s(`ZSD_SHIFT_OFF) |=> prdata[31:7] == 25'h0)
    else $error("shift wider than 7 bits");
  scale_width_a: assert property (
    rd_s(`ZSD_SCALE_OFF) |=> prdata[31:16] == 16'h0)
    else $error("scale wider than 16 bits");
  ovf_sticky_a: assert property (overflow |=> overflow)
    else $error("overflow flag dropped");
  valid_pulse_a: assert property (out_valid |=> !out_valid)
    else $error("valid held too long");
endmodule // zsd_core_monitor
bind zsd_core zsd_core_monitor u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .out_valid(out_valid), .overflow(overflow));
`default_nettype wire

// ---- tb/zsd_expander.sv ----
// model of the sample source behind a zero-stuffing expander
`timescale 1ns/1ns
`default_nettype none
module zsd_expander #(
  parameter int L = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw samples, taken once every L clocks
  input wire zsd_pkg::zsd_sample_t in_sample,
  // stuffed stream
  output var zsd_pkg::zsd_sample_t stuffed_sample
);
  import zsd_pkg::*;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  zsd_sample_t hold_reg;
  zsd_sample_t hold_next;
  // modulo-L counter; input rate is clock over L by construction
  always_comb begin
    cnt_next = (cnt_reg == 8'(L - 1)) ? 8'h00 : cnt_reg + 8'h01;
    hold_next = (cnt_reg == 8'h00) ? in_sample : hold_reg;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
      hold_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
    end
  end
  // and gating: L-1 zero slots after every real sample
  assign stuffed_sample = (cnt_reg == 8'(L - 1)) ? hold_reg : '0;
endmodule // zsd_expander
`default_nettype wire

// ---- tb/zero_stuff_decim_gain_test.sv ----
// self-checking bench for the zero stuff decimator
`timescale 1ns/1ns
`default_nettype none
`include "zsd_defs.svh"
module zero_stuff_decim_gain_test;
  import zsd_pkg::*;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic e;
    int t;
  } zsd_note_t;
  localparam int coarse_rate = 16;
  localparam int ZL = 64 / 16;
  localparam int CL = $clog2((coarse_rate ** 5) / ZL);
  localparam int SH = 75 - CL;
  localparam longint SC =
    ((longint'(ZL) << CL) << 15) / (coarse_rate ** 5);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic out_valid, overflow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, out_iq;
  zsd_sample_t amp, stuffed;
  zsd_note_t q[$];
  zsd_note_t nt;
  int err_count, compares, ov_cnt, cyc, di, dq;
  zsd_expander #(.L(ZL)) src (.pclk(pclk), .presetn(presetn),
    .in_sample(amp), .stuffed_sample(stuffed));
  zsd_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stuffed_sample(stuffed), .out_valid(out_valid), .out_iq(out_iq),
    .overflow(overflow));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // both levels within t of the expected word
  function automatic bit near(input int a, input int b, input int t);
    near = (a < 0 ? -a : a) <= t && (b < 0 ? -b : b) <= t;
  endfunction
  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one apb transfer; the note goes on the queue one edge before setup is driven
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic e, input int t);
    q.push_back('{d, m, e, t});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the request until ready is seen at a rising edge
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // watcher: settled outputs compared at the falling edge
  always @(negedge pclk) begin
    if (out_valid === 1'b1) ov_cnt++;
    if (pready === 1'b1) begin
      nt = q.pop_front();
      chk("pslverr", 32'(nt.e), 32'(pslverr));
      if (nt.t == 0) chk("prdata", nt.d & nt.m, prdata & nt.m);
      else begin
        // int arithmetic below would turn unknowns into zero
        chk("iq_known", 32'h0, 32'(^{prdata, out_iq} === 1'bx));
        chk("out_valid", 32'h1, 32'(out_valid));
        di = $signed(prdata[31:16]) - $signed(nt.d[31:16]);
        dq = $signed(prdata[15:0]);
        chk("iq_level", 32'h1, 32'(near(di, dq, nt.t)));
        di = $signed(out_iq[31:16]) - $signed(nt.d[31:16]);
        dq = $signed(out_iq[15:0]);
        chk("out_iq", 32'h1, 32'(near(di, dq, nt.t)));
      end
    end
  end
  // hang guard: the run needs well under 4000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, amp} = '0;
    void'($urandom(32'h84B0E702));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    amp <= 16'(($urandom % 32'h3000) + 32'h1000);
    apb(0, `ZSD_CTRL_OFF, 32'h0, 32'hFFFFFFFF, 0, 0);
    apb(0, `ZSD_RATE_OFF, 32'h10, 32'hFFFFFFFF, 0, 0);
    apb(0, `ZSD_SHIFT_OFF, 32'h37, 32'hFFFFFFFF, 0, 0);
    apb(0, `ZSD_SCALE_OFF, 32'h8000, 32'hFFFFFFFF, 0, 0);
    // rates under the floor are clamped
    for (int i = 0; i < 4; i++) begin
      apb(1, `ZSD_RATE_OFF, $urandom % 16, 32'h0, 0, 0);
      apb(0, `ZSD_RATE_OFF, 32'h10, 32'hFFFFFFFF, 0, 0);
    end
    apb(1, `ZSD_SCALE_OFF, 32'hFFFF, 32'h0, 0, 0);
    apb(0, `ZSD_SCALE_OFF, 32'hFFFF, 32'hFFFFFFFF, 0, 0);
    apb(0, 12'h020, 32'h0, 32'h0, 1, 0);
    apb(1, `ZSD_DATA_OFF, 32'h0, 32'h0, 1, 0);
    apb(1, `ZSD_RATE_OFF, coarse_rate, 32'h0, 0, 0);
    apb(1, `ZSD_SHIFT_OFF, SH, 32'h0, 0, 0);
    apb(1, `ZSD_SCALE_OFF, 32'(SC), 32'h0, 0, 0);
    apb(1, `ZSD_CTRL_OFF, 32'h1, 32'h0, 0, 0);
    // fill the buffer until it drops, then drain it
    repeat (1400) @(posedge pclk);
    apb(0, `ZSD_STAT_OFF, 32'h21, 32'h7F, 0, 0);
    repeat (16) apb(0, `ZSD_DATA_OFF, 32'h0, 32'h0, 0, 0);
    repeat (192) @(posedge pclk);
    apb(0, `ZSD_DATA_OFF, {amp, 16'h0}, 32'h0, 0, 256);
    repeat (4) @(posedge pclk);
    chk("pop_count", 32'd17, 32'(ov_cnt));
    chk("overflow", 32'h0, 32'(overflow));
    conclude();
  end
endmodule // zero_stuff_decim_gain_test
`default_nettype wire
